// File: rtl/tone_pkg.sv
// Constants shared by the buzzer tone generator and its divider chain.
// Assumes a single 50 MHz clock and an APB master in the same domain.
package tone_pkg;
	localparam logic [15:0] TONE_CONTROL_ADDR = 16'hFF64;
	localparam int ON_BIT = 0;
	localparam int SELECT_BIT = 1;
	localparam int INTERVAL_BIT = 2;
	localparam logic [15:0] PRESCALER_ADDR = 16'hFF60;
	localparam int PRESCALER_WIDTH = 4;
	localparam logic [3:0] CONTROL_RESET = 4'h0;
	localparam logic [PRESCALER_WIDTH-1:0] PRESCALER_RESET = 4'h0;
	// Divider taps: bit 6 toggles at fprs/128, bit 7 at /256, bit 17 at /262144
	localparam int CHAIN_WIDTH = 18;
	localparam int HIGH_TAP = 6;
	localparam int LOW_TAP = 7;
	localparam int INTERVAL_TAP = 17;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// File: rtl/tone_div_if.sv
`timescale 1ns/1ps
// Carries prescaler setting in and divider taps out between the two modules.
// Assumes both ends run on the same clock.
interface tone_div_if;
	import tone_pkg::*;
	logic [PRESCALER_WIDTH-1:0] prescalerSetting;
	logic highTone;
	logic lowTone;
	logic intervalGate;
	modport ctrl(output prescalerSetting, input highTone, input lowTone, input intervalGate);
	modport div(input prescalerSetting, output highTone, output lowTone, output intervalGate);
endinterface

// File: rtl/tone_divider.sv
`timescale 1ns/1ps
// Prescaler enable pulse and free-running binary divider chain.
// Assumes the prescaler setting is stable from a register in the same domain.
module tone_divider (
	input wire logic clk,
	input wire logic rst_n,
	tone_div_if.div link
);
	import tone_pkg::*;

	logic [PRESCALER_WIDTH-1:0] preCount_reg, preCount_next;
	logic [CHAIN_WIDTH-1:0] chain_reg, chain_next;
	logic prsTick;

	// ----------------------------------------
	// Prescaler and chain
	// ----------------------------------------
	// Prescaler divides by setting plus one; the chain never stops
	always_comb begin
		prsTick = (preCount_reg >= link.prescalerSetting);
		preCount_next = prsTick ? '0 : preCount_reg + 1'b1;
		chain_next = prsTick ? chain_reg + 1'b1 : chain_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			preCount_reg <= '0;
			chain_reg <= '0;
		end else begin
			preCount_reg <= preCount_next;
			chain_reg <= chain_next;
		end
	end

	// Square waves with equal halves
	assign link.highTone = chain_reg[HIGH_TAP];
	assign link.lowTone = chain_reg[LOW_TAP];
	assign link.intervalGate = chain_reg[INTERVAL_TAP];

	chk_interval_half: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(link.intervalGate) |-> $past(chain_reg[INTERVAL_TAP-1:0]) == '1)
		else $error("interval gate rose early");
	chk_low_half: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(link.lowTone) |-> $changed(link.highTone))
		else $error("low tone not half of high tone");
endmodule

// File: rtl/buzzer_tone_generator.sv
`timescale 1ns/1ps
// Buzzer tone generator top: APB registers, tone select, gating and pin.
// Assumes a synchronous APB master on clk and an external transistor driver.
module buzzer_tone_generator #(
	parameter bit NEGATIVE_POLARITY = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tonePin
);
	import tone_pkg::*;

	logic [3:0] control_reg, control_next;
	logic [PRESCALER_WIDTH-1:0] prescaler_reg, prescaler_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next;
	logic tonePin_next;
	logic toneOn, toneSelect, intervalOn;
	logic wave, gated;
	logic setupPhase, accessDone, hitControl, hitPrescaler;

	tone_div_if divLink();

	tone_divider u_divider (
		.clk(clk),
		.rst_n(rst_n),
		.link(divLink)
	);

	assign divLink.prescalerSetting = prescaler_reg;
	assign toneOn = control_reg[ON_BIT];
	assign toneSelect = control_reg[SELECT_BIT];
	assign intervalOn = control_reg[INTERVAL_BIT];

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Answer in the access cycle after setup: no wait state, pready pulsed from a flop
	always_comb begin
		setupPhase = psel && !penable;
		accessDone = psel && penable && pready;
		hitControl = (paddr == TONE_CONTROL_ADDR);
		hitPrescaler = (paddr == PRESCALER_ADDR);
		control_next = control_reg;
		prescaler_next = prescaler_reg;
		prdata_next = prdata;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		if (setupPhase) begin
			pready_next = 1'b1;
			pslverr_next = !(hitControl || hitPrescaler);
			prdata_next = UNMAPPED_READ;
			if (!pwrite && hitControl) begin
				prdata_next = {28'h0000000, control_reg};
			end else if (!pwrite && hitPrescaler) begin
				prdata_next = {28'h0000000, prescaler_reg};
			end
		end
		// Writes land only at the edge that completes the transfer
		if (accessDone && pwrite) begin
			if (hitControl) begin
				// Bit 3 is never stored so it reads back 0
				control_next = {1'b0, pwdata[INTERVAL_BIT:ON_BIT]};
			end
			if (hitPrescaler) begin
				prescaler_next = pwdata[PRESCALER_WIDTH-1:0];
			end
		end
	end

	// Read data launches on the setup edge; writes commit on the access edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= CONTROL_RESET;
			prescaler_reg <= PRESCALER_RESET;
			prdata <= UNMAPPED_READ;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			control_reg <= control_next;
			prescaler_reg <= prescaler_next;
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// ----------------------------------------
	// Tone path
	// ----------------------------------------
	// Enable is applied without resync to the wave, so a short pulse may occur
	always_comb begin
		wave = toneSelect ? divLink.lowTone : divLink.highTone;
		gated = wave && (!intervalOn || divLink.intervalGate);
		if (toneOn) begin
			tonePin_next = gated ^ NEGATIVE_POLARITY;
		end else begin
			tonePin_next = NEGATIVE_POLARITY;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tonePin <= 1'b0;
		end else begin
			tonePin <= tonePin_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence sWriteOff;
		psel && !penable && pwrite && hitControl && !pwdata[ON_BIT];
	endsequence

	// A completed write to the control register
	sequence sAccessWrite;
		psel && penable && pready && pwrite && hitControl;
	endsequence

	// A completed write to an address that has no register behind it
	sequence sAccessUnmapped;
		psel && penable && pready && pwrite && !hitControl && !hitPrescaler;
	endsequence

	// Setup, one cycle to commit, one cycle for the pin flop
	chk_idle_level: assert property (@(posedge clk) disable iff (!rst_n)
		sWriteOff ##2 1'b1 |=> tonePin == NEGATIVE_POLARITY)
		else $error("pin not idle after enable cleared");
	chk_bit3_zero: assert property (@(posedge clk) disable iff (!rst_n)
		pready |-> !(hitControl && prdata[3]))
		else $error("unused bit read as one");
	chk_readback: assert property (@(posedge clk) disable iff (!rst_n)
		psel && !penable && !pwrite && hitControl |=> prdata[2:0] == $past(control_reg[2:0]))
		else $error("control readback mismatch");
	chk_select_low: assert property (@(posedge clk) disable iff (!rst_n)
		toneOn && toneSelect && !intervalOn |=> tonePin == (divLink.lowTone ^ $past(NEGATIVE_POLARITY)) || $changed(divLink.lowTone) || $changed(control_reg))
		else $error("low tone not on pin");
	chk_gate_mute: assert property (@(posedge clk) disable iff (!rst_n)
		toneOn && intervalOn && !divLink.intervalGate && $stable(control_reg) |=> tonePin == NEGATIVE_POLARITY)
		else $error("gated tone not muted");
	chk_enable_needed: assert property (@(posedge clk) disable iff (!rst_n)
		!toneOn && intervalOn |=> tonePin == NEGATIVE_POLARITY)
		else $error("interval drove pin without enable");
	chk_reset_clear: assert property (@(posedge clk)
		!rst_n |-> control_reg == CONTROL_RESET)
		else $error("control not cleared by reset");
	chk_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		pready |=> !pready)
		else $error("pready held too long");

	// Stored bits follow the written word at the completing edge
	chk_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		sAccessWrite |=> control_reg[2:0] == $past(pwdata[2:0]))
		else $error("control write did not land");
	// The unused bit never holds a one
	chk_bit3_store: assert property (@(posedge clk) disable iff (!rst_n)
		!control_reg[3])
		else $error("unused control bit set");
	// Unmapped writes leave the control bits alone
	chk_unmapped_keep: assert property (@(posedge clk) disable iff (!rst_n)
		sAccessUnmapped |=> $stable(control_reg))
		else $error("unmapped write changed control");
	// Error only ever comes with the answer
	chk_slverr_pair: assert property (@(posedge clk) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("slave error without ready");
	// Unmapped reads return zero
	chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
		pready && pslverr |-> prdata == UNMAPPED_READ)
		else $error("unmapped read not zero");
	// Control holds between transfers, so readback is what was stored
	chk_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!psel |=> $stable(control_reg))
		else $error("control changed without a transfer");
	// Output enable off forces the idle level one cycle later
	chk_pin_off: assert property (@(posedge clk) disable iff (!rst_n)
		!toneOn |=> tonePin == NEGATIVE_POLARITY)
		else $error("pin not idle while disabled");
	// High tone selected: pin follows the high tap through one flop
	chk_high_sel: assert property (@(posedge clk) disable iff (!rst_n)
		toneOn && !toneSelect && !intervalOn |=>
		tonePin == ($past(divLink.highTone) ^ NEGATIVE_POLARITY))
		else $error("high tone not on pin");
	// Low tone selected: pin follows the low tap through one flop
	chk_low_sel: assert property (@(posedge clk) disable iff (!rst_n)
		toneOn && toneSelect && !intervalOn |=>
		tonePin == ($past(divLink.lowTone) ^ NEGATIVE_POLARITY))
		else $error("low tone tap not on pin");
	// Open gate half lets the selected wave through
	chk_gate_pass: assert property (@(posedge clk) disable iff (!rst_n)
		toneOn && intervalOn && divLink.intervalGate |=>
		tonePin == ($past(wave) ^ NEGATIVE_POLARITY))
		else $error("gated tone not passed");
endmodule

// File: testbench/buzzer_model.sv
// Piezo buzzer behind its transistor: times the pin between rising edges.
// Assumes the pin is sampled on the block clock.
`timescale 1ns/1ps
module buzzer_model (
	input wire logic clk,
	input wire logic tonePin,
	output logic [31:0] period
);
	logic [31:0] countReg;
	logic pinReg;
	// Clocks between rises; a truncated first pulse is overwritten later
	always_ff @(posedge clk) begin
		pinReg <= tonePin;
		countReg <= (tonePin && !pinReg) ? 32'h1 : countReg + 32'h1;
		if (tonePin && !pinReg) begin
			period <= countReg;
		end
	end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the buzzer tone generator over APB.
// Assumes positive polarity and the buzzer model on the pin.
`timescale 1ns/1ps
module tb;
	import tone_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tonePin, err, seenHigh;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rdata, period;
	int error_cnt, tests_run, cycles;
	buzzer_tone_generator u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tonePin(tonePin));
	buzzer_model u_buzzer (.clk(clk), .tonePin(tonePin), .period(period));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One APB transfer; the leading edge keeps strobes from being set twice
	task apb(input logic wr, input logic [15:0] addr, input logic [31:0] data);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Pin must stay at its idle low level for the whole window
	task quiet(input int n);
		seenHigh = 1'b0;
		repeat (n) begin
			@(posedge clk);
			seenHigh = seenHigh | tonePin;
		end
		check("pin idle", {31'h0, seenHigh}, 32'h0);
	endtask
	task tone(input logic [31:0] ctrl, input logic [31:0] presc, input logic [31:0] exp);
		apb(1'b1, PRESCALER_ADDR, presc);
		apb(1'b1, TONE_CONTROL_ADDR, ctrl);
		repeat (800) @(posedge clk);
		check("tone period", period, exp);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, TONE_CONTROL_ADDR, 32'h0);
		check("control reset", rdata, 32'h0000_0000);
		quiet(20);
		apb(1'b1, TONE_CONTROL_ADDR, 32'h0000_000F);
		apb(1'b0, TONE_CONTROL_ADDR, 32'h0);
		check("control readback", rdata, 32'h0000_0007);
		apb(1'b0, 16'hFF68, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h0000_0001);
		check("unmapped data", rdata, 32'h0000_0000);
		// Gate is still in its muted first half long after reset
		quiet(600);
		apb(1'b1, TONE_CONTROL_ADDR, 32'h0000_0004);
		quiet(600);
		tone(32'h0000_0001, 32'h0, 32'h0000_0080);
		tone(32'h0000_0003, 32'h0, 32'h0000_0100);
		tone(32'h0000_0001, 32'h1, 32'h0000_0100);
		apb(1'b0, PRESCALER_ADDR, 32'h0);
		check("prescaler readback", rdata, 32'h0000_0001);
		apb(1'b1, TONE_CONTROL_ADDR, 32'h0);
		quiet(600);
		stop_test();
	end
endmodule
